// ### hdl/ocp_pkg.sv
// Purpose: Shared constants and types for the output compare channel.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Register fields are carried as packed structs.
package ocp_pkg;
  localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h04;
  localparam logic [7:0] ADDR_FIRST       = 8'h08;
  localparam logic [7:0] ADDR_SECOND      = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD      = 8'h10;
  localparam logic [7:0] ADDR_COUNT       = 8'h14;
  localparam logic [15:0] CTRL_ONE_RESET  = 16'h0000;
  localparam logic [15:0] CTRL_TWO_RESET  = 16'h000c;
  localparam logic [15:0] CTRL_ONE_WMASK  = 16'h3c9f;
  localparam logic [15:0] CTRL_TWO_WMASK  = 16'hf1ff;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [15:0] COUNT_ONE       = 16'h0001;
  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  localparam logic [2:0]  TB_TIMER2       = 3'h0;
  localparam logic [2:0]  TB_TIMER3       = 3'h1;
  localparam logic [2:0]  TB_TIMER4       = 3'h2;
  localparam logic [2:0]  TB_TIMER5       = 3'h3;
  localparam logic [2:0]  TB_TIMER1       = 3'h4;
  localparam logic [2:0]  TB_PCLK         = 3'h7;
  localparam logic [4:0]  SRC_NONE        = 5'h00;
  localparam logic [4:0]  SRC_SELF        = 5'h1f;
  localparam int          FAULT_A_LAST    = 4;

  typedef enum logic [2:0] {
    MODE_OFF         = 3'b000,
    MODE_SINGLE_RISE = 3'b001,
    MODE_SINGLE_FALL = 3'b010,
    MODE_TOGGLE      = 3'b011,
    MODE_DOUBLE_ONCE = 3'b100,
    MODE_DOUBLE_CONT = 3'b101,
    MODE_PWM_EDGE    = 3'b110,
    MODE_PWM_CENTER  = 3'b111
  } ocp_mode_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       idle_stop;
    logic [2:0] time_base_select;
    logic [1:0] rsv_mid;
    logic       fault_input_enable;
    logic [1:0] rsv_lo;
    logic       fault_status;
    logic       trigger_clear_mode;
    ocp_mode_t  channel_mode;
  } ocp_ctrl_one_t;

  typedef struct packed {
    logic       fault_exit_mode;
    logic       fault_drive_level;
    logic       fault_force_output;
    logic       output_invert;
    logic [2:0] rsv;
    logic       cascade_enable;
    logic       trigger_or_sync_select;
    logic       trigger_status;
    logic       output_tristate;
    logic [4:0] source_select;
  } ocp_ctrl_two_t;
endpackage : ocp_pkg

// ### hdl/ocp_channel.sv
// Purpose: One output compare / PWM channel with an APB register slave.
// Assumes: Timer ticks and source events come from logic on pclk.
// Notes:   Fault pins are asynchronous and pass two flip-flops first.
// How it works
// - PWM period lasts period_register plus one time base counts.
// - PWM duty values latch into active copies only at period match.
// - All compare values and period zero give a constant low output.
// - Second compare above period gives a constant high output.
// - Time base select picks timer 2,3,4,5,1 or peripheral clock.
// - Fault input enable bit gates the fault input.
// - Hardware sets fault status on a fault; used only in mode 111.
// - Trigger clear mode lets a second compare match clear trigger status.
// - Mode 111 center PWM, 110 edge PWM, 000 disabled.
// - Modes 101/100 start low, toggle on alternating matches, 100 once.
// - Mode 011 toggles, 010 starts high then low, 001 low then high.
// - Fault input A serves channels one to four, B five to nine.
// - Compare modes use written compare values at once.
// - Fault exit waits for source removal and new period, maybe sw clear.
// - During a fault the output takes the fault drive level.
// - Fault force output makes the pin an output during a fault.
// - Output invert inverts the channel output.
// - Cascade enable chains two channels as one 32-bit channel.
// - Trigger or sync select picks trigger or counter sync role.
// - Trigger status is set by hardware when triggered and running.
// - Output tristate releases the pin when set.
// - Source select codes: none, channels, timers, others, self.
// - Free-running counter counts up and wraps from all ones to zero.
// - Interrupt flag on first match single, second match double modes.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module ocp_channel
  import ocp_pkg::*;
#(
  parameter int CHANNEL_NUM = 1       // Channel number, one to nine.
) (
  input  wire logic        pclk,           // APB clock.
  input  wire logic        presetn,        // Asynchronous reset, low.
  input  wire logic        psel,           // APB select.
  input  wire logic        penable,        // APB access phase.
  input  wire logic        pwrite,         // APB write.
  input  wire logic [7:0]  paddr,          // APB byte address.
  input  wire logic [31:0] pwdata,         // APB write data.
  output logic      [31:0] prdata,         // APB read data.
  output logic             pready,         // APB ready.
  output logic             pslverr,        // APB error.
  input  wire logic [4:0]  timer_tick,     // Timers 2,3,4,5,1 ticks.
  input  wire logic [31:0] source_event,   // Events by source code.
  input  wire logic        cascade_in,     // Carry from lower channel.
  output logic             cascade_carry,  // Carry to upper channel.
  input  wire logic        fault_input_a,  // Fault pin A, high = fault.
  input  wire logic        fault_input_b,  // Fault pin B, high = fault.
  output logic             channel_output, // Pin drive level.
  output logic             channel_oe,     // Pin output enable.
  output logic             channel_interrupt_flag // Event pulse.
);
  ocp_ctrl_one_t ctl1;
  ocp_ctrl_two_t ctl2;
  logic [15:0] first_compare_value;
  logic [15:0] second_compare_value;
  logic [15:0] period_register;
  logic [15:0] active_first;
  logic [15:0] active_second;
  logic [15:0] internal_counter;
  logic [15:0] next_counter;
  logic [1:0]  fault_meta;
  logic [1:0]  fault_sync;
  logic        out_state;
  logic        next_out;
  logic        phase;
  logic        done;
  logic        fault_active;

  // Time base decode.
  function automatic logic tick_pick(input logic [2:0] sel,
                                     input logic [4:0] ticks);
    logic r;
    r = 1'b0;
    if (sel == TB_TIMER2) r = ticks[0];
    else if (sel == TB_TIMER3) r = ticks[1];
    else if (sel == TB_TIMER4) r = ticks[2];
    else if (sel == TB_TIMER5) r = ticks[3];
    else if (sel == TB_TIMER1) r = ticks[4];
    else if (sel == TB_PCLK) r = 1'b1;
    return r;
  endfunction : tick_pick

  // APB decode; the slave never waits.
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire sel_one  = (paddr == ADDR_CONTROL_ONE);
  wire sel_two  = (paddr == ADDR_CONTROL_TWO);
  wire sel_fst  = (paddr == ADDR_FIRST);
  wire sel_snd  = (paddr == ADDR_SECOND);
  wire sel_per  = (paddr == ADDR_PERIOD);
  wire sel_cnt  = (paddr == ADDR_COUNT);
  wire mapped   = sel_one || sel_two || sel_fst || sel_snd || sel_per ||
                  sel_cnt;
  wire wr_one   = wr && sel_one;
  wire wr_two   = wr && sel_two;
  wire [15:0] wdata = pwdata[15:0];
  wire [15:0] rmux  = sel_one ? ctl1 : sel_two ? ctl2 :
                      sel_fst ? first_compare_value :
                      sel_snd ? second_compare_value :
                      sel_per ? period_register :
                      sel_cnt ? internal_counter : WORD_ZERO;
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // Mode and source decode.
  ocp_mode_t mode;
  assign mode = ctl1.channel_mode;
  wire is_pwm    = (mode == MODE_PWM_EDGE) || (mode == MODE_PWM_CENTER);
  wire is_single = (mode == MODE_SINGLE_RISE) ||
                   (mode == MODE_SINGLE_FALL) || (mode == MODE_TOGGLE);
  wire is_double = (mode == MODE_DOUBLE_ONCE) ||
                   (mode == MODE_DOUBLE_CONT);
  wire upper     = ctl2.cascade_enable && (CHANNEL_NUM % 2 == 0);
  // An upper half of a cascade counts on the lower half's carry.
  wire tick      = upper ? cascade_in :
                   tick_pick(ctl1.time_base_select, timer_tick);
  wire has_src   = (ctl2.source_select != SRC_NONE);
  wire trig_mode = has_src && ctl2.trigger_or_sync_select;
  wire sync_mode = has_src && !ctl2.trigger_or_sync_select;
  wire held      = trig_mode && !ctl2.trigger_status;
  wire running   = (mode != MODE_OFF) && !held;
  wire at_period = (internal_counter == period_register);
  wire per_match = tick && running && at_period;
  // Self selection only makes sense as sync to the own period.
  wire src_evt   = (ctl2.source_select == SRC_SELF) ? per_match :
                   source_event[ctl2.source_select];
  wire trig_evt  = trig_mode && src_evt;
  wire sync_evt  = sync_mode && src_evt;
  wire m1        = tick && running && (internal_counter == active_first);
  wire m2        = tick && running && (internal_counter == active_second);
  wire take1     = is_single && m1 && !done;
  wire take2     = is_double && m2 && phase && !done;

  // Counter: PWM restarts after the period count, others wrap freely.
  always_comb begin
    next_counter = internal_counter;
    if (!running) begin
      next_counter = WORD_ZERO;
    end else if (sync_evt) begin
      next_counter = WORD_ZERO;
    end else if (tick) begin
      if (is_pwm && at_period) begin
        next_counter = WORD_ZERO;
      end else begin
        next_counter = internal_counter + COUNT_ONE;
      end
    end
  end

  // Edge and center PWM share the level law; compare with active copies.
  wire pwm_level = (active_second > period_register) ||
                   ((internal_counter >= active_first) &&
                    (internal_counter < active_second));

  always_comb begin
    next_out = out_state;
    case (mode)
      MODE_OFF:         next_out = 1'b0;
      MODE_SINGLE_RISE: if (take1) next_out = 1'b1;
      MODE_SINGLE_FALL: if (take1) next_out = 1'b0;
      MODE_TOGGLE:      if (m1) next_out = !out_state;
      MODE_DOUBLE_ONCE,
      MODE_DOUBLE_CONT: begin
        if (!done && !phase && m1) next_out = 1'b1;
        else if (take2) next_out = 1'b0;
      end
      default:          next_out = pwm_level;
    endcase
  end

  // Fault handling: only center-aligned PWM honours the fault pin.
  wire fault_raw  = (CHANNEL_NUM <= FAULT_A_LAST) ? fault_sync[0] :
                    fault_sync[1];
  wire fault_live = fault_raw && ctl1.fault_input_enable &&
                    (mode == MODE_PWM_CENTER);
  wire fault_end  = !fault_live && per_match &&
                    (!ctl2.fault_exit_mode || !ctl1.fault_status);
  wire sw_fclr    = wr_one && !wdata[4] && ctl2.fault_exit_mode;
  wire hw_fclr    = fault_active && fault_end && !ctl2.fault_exit_mode;
  wire lvl_norm   = out_state ^ ctl2.output_invert;
  wire pin_level  = fault_active ? ctl2.fault_drive_level : lvl_norm;
  wire pin_oe     = !ctl2.output_tristate ||
                    (fault_active && ctl2.fault_force_output);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_meta <= 2'h0;
      fault_sync <= 2'h0;
    end else begin
      fault_meta <= {fault_input_b, fault_input_a};
      fault_sync <= fault_meta;
    end
  end

  // Control one; a write rearms single-shot modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1 <= CTRL_ONE_RESET;
    end else begin
      if (wr_one) ctl1 <= (wdata & CTRL_ONE_WMASK) | {11'h000,
                          ctl1.fault_status, 4'h0};
      if (fault_live) ctl1.fault_status <= 1'b1;
      else if (sw_fclr || hw_fclr) ctl1.fault_status <= 1'b0;
    end
  end

  // Control two; a trigger event wins over any clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl2 <= CTRL_TWO_RESET;
    end else begin
      if (wr_two) ctl2 <= wdata & CTRL_TWO_WMASK;
      if (trig_evt) ctl2.trigger_status <= 1'b1;
      else if (ctl1.trigger_clear_mode && m2)
        ctl2.trigger_status <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_compare_value  <= WORD_ZERO;
      second_compare_value <= WORD_ZERO;
      period_register      <= WORD_ZERO;
    end else begin
      if (wr && sel_fst) first_compare_value <= wdata;
      if (wr && sel_snd) second_compare_value <= wdata;
      if (wr && sel_per) period_register <= wdata;
    end
  end

  // Duty copies: buffered in PWM, transparent in compare modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_first  <= WORD_ZERO;
      active_second <= WORD_ZERO;
    end else if (!is_pwm || per_match) begin
      active_first  <= first_compare_value;
      active_second <= second_compare_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      internal_counter <= WORD_ZERO;
    end else begin
      internal_counter <= next_counter;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_state <= 1'b0;
      phase     <= 1'b0;
      done      <= 1'b0;
    end else if (wr_one) begin
      out_state <= (wdata[2:0] == MODE_SINGLE_FALL);
      phase     <= 1'b0;
      done      <= 1'b0;
    end else begin
      out_state <= next_out;
      if (is_double && !done && !phase && m1) phase <= 1'b1;
      else if (take2) phase <= 1'b0;
      if (take1 && mode != MODE_TOGGLE) done <= 1'b1;
      if (take2 && mode == MODE_DOUBLE_ONCE) done <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_active <= 1'b0;
    end else if (fault_live) begin
      fault_active <= 1'b1;
    end else if (fault_end) begin
      fault_active <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                 <= 32'h0000_0000;
      channel_output         <= 1'b0;
      channel_oe             <= 1'b0;
      channel_interrupt_flag <= 1'b0;
      cascade_carry          <= 1'b0;
    end else begin
      if (psel && !penable) prdata <= {16'h0000, rmux};
      channel_output         <= pin_level;
      channel_oe             <= pin_oe;
      channel_interrupt_flag <= take1 || (is_single && m1 &&
                                mode == MODE_TOGGLE) || take2;
      cascade_carry          <= tick && running &&
                                internal_counter == COUNT_MAX;
    end
  end

  sequence s_fault_seen;
    fault_live;
  endsequence
  sequence s_pin_fault;
    channel_output == ctl2.fault_drive_level;
  endsequence

  AST_PERIOD_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pwm && per_match && !sync_evt && !wr_one) |=>
    internal_counter == WORD_ZERO)
    else $error("counter did not restart after period");
  AST_DUTY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pwm && !per_match) |=> $stable(active_first))
    else $error("duty copy changed inside a period");
  AST_ZERO_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pwm && active_second == WORD_ZERO && !wr_one) |=> !out_state)
    else $error("zero duty output went high");
  AST_FULL_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pwm && active_second > period_register && !wr_one)
    |=> out_state)
    else $error("full duty output went low");
  AST_FAULT_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    s_fault_seen ##1 fault_active |=> s_pin_fault)
    else $error("pin not at fault level during fault");
  AST_FAULT_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    s_fault_seen |=> ctl1.fault_status && fault_active)
    else $error("fault not recorded");
  AST_TRISTATE: assert property (@(posedge pclk) disable iff (!presetn)
    (ctl2.output_tristate && !fault_active) |=> !channel_oe)
    else $error("pin driven while tristated");
  AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    (!is_pwm && running && tick && !sync_evt && !wr_one &&
     internal_counter == COUNT_MAX) |=> internal_counter == WORD_ZERO)
    else $error("counter did not wrap");
  AST_TRIG_HELD: assert property (@(posedge pclk) disable iff (!presetn)
    (held && !wr_one) |=> internal_counter == WORD_ZERO)
    else $error("counter ran while awaiting trigger");
  AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
    (is_double && m2 && phase && !done) |=> channel_interrupt_flag)
    else $error("no flag on second match");
  AST_SINGLE_RISE: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_SINGLE_RISE && take1 && !wr_one) |=> out_state)
    else $error("single rise did not rise");
endmodule : ocp_channel

// ### testbench/ocp_tick_model.sv
// Purpose: Timer ticks and source events seen by the channel.
// Assumes: All on-chip timers run from pclk, as in the real device.
// Notes:   Timer slot i ticks every i+2 cycles so the rates differ.
`timescale 1ns/10ps
module ocp_tick_model (
  input  wire logic        pclk,        // Clock.
  input  wire logic        presetn,     // Reset, active low.
  output logic      [4:0]  timer_tick,  // Tick pulses, T2 T3 T4 T5 T1.
  output logic      [31:0] source_event // Event pulses by source code.
);
  int unsigned cnt;

  // Timer ticks also appear as events on the timer source codes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt          <= 0;
      timer_tick   <= 5'h00;
      source_event <= 32'h0000_0000;
    end else begin
      cnt <= cnt + 1;
      for (int i = 0; i < 5; i++) begin
        timer_tick[i] <= (cnt % (i + 2)) == 0;
      end
      source_event        <= 32'h0000_0000;
      source_event[11]    <= (cnt % 6) == 0;
      source_event[15:12] <= {(cnt % 5) == 0, (cnt % 4) == 0,
                              (cnt % 3) == 0, (cnt % 2) == 0};
    end
  end
endmodule : ocp_tick_model

// ### testbench/tb_output_compare_pwm_channel.sv
// Purpose: Self-checking bench for the output compare channel.
// Assumes: Zero-wait APB slave; prdata is steady in the access cycle.
// Notes:   PWM rows are judged by high and rising counts in a window.
`timescale 1ns/10ps
module tb_output_compare_pwm_channel;
  import ocp_pkg::*;
  typedef struct packed {
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] first;
    logic [15:0] second;
    logic [15:0] period;
    logic [7:0]  highs;
    logic [7:0]  rises;
  } ocp_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, c;
  logic [4:0]  timer_tick;
  logic [31:0] source_event;
  logic        fault_input_a, fault_input_b, err;
  logic        channel_output, channel_oe, channel_interrupt_flag;
  int          n_mismatch, comparisons, cycles, highs, rises;
  ocp_row_t    rows [7];

  ocp_tick_model model (.pclk(pclk), .presetn(presetn),
    .timer_tick(timer_tick), .source_event(source_event));
  ocp_channel #(.CHANNEL_NUM(1)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_tick(timer_tick),
    .source_event(source_event), .cascade_in(1'b0), .cascade_carry(),
    .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
    .channel_output(channel_output), .channel_oe(channel_oe),
    .channel_interrupt_flag(channel_interrupt_flag));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // The run should need under a thousand cycles; a hang stops here.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Upper write half carries junk: only the low 16 bits may be taken.
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [15:0] wdata);
    int guard;
    guard = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {16'ha5a5, wdata};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      guard++;
    end while (pready !== 1'b1 && guard < 50);
    r       = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
    apb(1'b0, addr, 16'h0000);
    check(r, {16'h0000, exp});
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  task automatic measure();
    logic prev;
    highs = 0;
    rises = 0;
    @(negedge pclk);
    prev = channel_output;
    repeat (32) begin
      @(negedge pclk);
      highs += int'(channel_output === 1'b1);
      rises += int'(prev === 1'b0 && channel_output === 1'b1);
      prev = channel_output;
    end
  endtask : measure

  initial begin
    {psel, penable, pwrite, fault_input_a, fault_input_b} = 5'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    presetn = 1'b0;
    rows[0] = {16'h1c06, 16'h0000, 16'h0000, 16'h0003, 16'h0007,
               8'h0c, 8'h04};
    rows[1] = {16'h1c06, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
               8'h00, 8'h00};
    rows[2] = {16'h1c06, 16'h0000, 16'h0000, 16'h0009, 16'h0007,
               8'h20, 8'h00};
    rows[3] = {16'h1c06, 16'h1000, 16'h0000, 16'h0000, 16'h0000,
               8'h20, 8'h00};
    rows[4] = {16'h1c07, 16'h0000, 16'h0002, 16'h0006, 16'h0007,
               8'h10, 8'h04};
    rows[5] = {16'h0006, 16'h0000, 16'h0000, 16'h0003, 16'h0007,
               8'h0c, 8'h02};
    rows[6] = {16'h1c00, 16'h0000, 16'h0000, 16'h0003, 16'h0007,
               8'h00, 8'h00};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({channel_output, channel_oe}, 2'b00);
    rd(ADDR_CONTROL_ONE, CTRL_ONE_RESET);
    rd(ADDR_CONTROL_TWO, CTRL_TWO_RESET);
    apb(1'b0, 8'h1c, 16'h0000);
    check({err, r}, {1'b1, 32'h0000_0000});
    apb(1'b1, ADDR_COUNT, 16'hffff);
    rd(ADDR_COUNT, WORD_ZERO);
    apb(1'b1, ADDR_FIRST, 16'hffff);
    rd(ADDR_FIRST, 16'hffff);
    $display("test registers done");

    foreach (rows[i]) begin
      apb(1'b1, ADDR_CONTROL_ONE, 16'h0000);
      apb(1'b1, ADDR_FIRST, rows[i].first);
      apb(1'b1, ADDR_SECOND, rows[i].second);
      apb(1'b1, ADDR_PERIOD, rows[i].period);
      apb(1'b1, ADDR_CONTROL_TWO, rows[i].c2);
      apb(1'b1, ADDR_CONTROL_ONE, rows[i].c1);
      settle(40);
      measure();
      check(32'(highs), 32'(rows[i].highs));
      check(32'(rises), 32'(rows[i].rises));
      $display("test pwm row %0d done", i);
    end

    // Counter runs every cycle on code 7 and not at all on a reserved code.
    apb(1'b1, ADDR_CONTROL_ONE, 16'h0000);
    apb(1'b1, ADDR_PERIOD, COUNT_MAX);
    apb(1'b1, ADDR_FIRST, COUNT_MAX);
    apb(1'b1, ADDR_CONTROL_ONE, 16'h1c01);
    apb(1'b0, ADDR_COUNT, 16'h0000);
    c = r;
    apb(1'b0, ADDR_COUNT, 16'h0000);
    check(r - c, 32'h0000_0003);
    apb(1'b1, ADDR_CONTROL_ONE, 16'h1401);
    apb(1'b0, ADDR_COUNT, 16'h0000);
    c = r;
    apb(1'b0, ADDR_COUNT, 16'h0000);
    check(r, c);
    $display("test counter done");

    // Single compare: a new first value acts at once outside PWM.
    apb(1'b1, ADDR_FIRST, 16'(c + 32'h0000_0020));
    apb(1'b1, ADDR_CONTROL_ONE, 16'h1c01);
    settle(2);
    check(channel_output, 1'b0);
    highs = 0;
    while (channel_interrupt_flag !== 1'b1 && highs < 200) begin
      @(negedge pclk);
      highs++;
    end
    check(channel_interrupt_flag, 1'b1);
    settle(3);
    check(channel_output, 1'b1);
    apb(1'b1, ADDR_CONTROL_ONE, 16'h1c02);
    settle(3);
    check(channel_output, 1'b1);
    $display("test compare done");

    // Fault handling on channel one, which listens to pin A only.
    apb(1'b1, ADDR_CONTROL_ONE, 16'h0000);
    apb(1'b1, ADDR_FIRST, WORD_ZERO);
    apb(1'b1, ADDR_SECOND, WORD_ZERO);
    apb(1'b1, ADDR_PERIOD, WORD_ZERO);
    apb(1'b1, ADDR_CONTROL_TWO, 16'h6020);
    apb(1'b1, ADDR_CONTROL_ONE, 16'h1c87);
    settle(8);
    check({channel_output, channel_oe}, 2'b00);
    @(posedge pclk) fault_input_b <= 1'b1;
    settle(8);
    check(channel_output, 1'b0);
    @(posedge pclk) fault_input_b <= 1'b0;
    @(posedge pclk) fault_input_a <= 1'b1;
    settle(8);
    check({channel_output, channel_oe}, 2'b11);
    rd(ADDR_CONTROL_ONE, 16'h1c97);
    @(posedge pclk) fault_input_a <= 1'b0;
    settle(8);
    check({channel_output, channel_oe}, 2'b00);
    rd(ADDR_CONTROL_ONE, 16'h1c87);
    apb(1'b1, ADDR_CONTROL_ONE, 16'h1c07);
    @(posedge pclk) fault_input_a <= 1'b1;
    settle(8);
    check(channel_output, 1'b0);
    @(posedge pclk) fault_input_a <= 1'b0;
    $display("test fault done");

    // Source code 0b is a timer that fires every six cycles and sets status.
    apb(1'b1, ADDR_CONTROL_TWO, 16'h008b);
    settle(8);
    rd(ADDR_CONTROL_TWO, 16'h00cb);
    // A reset in mid-run must clear the pin and restore control two.
    @(posedge pclk) presetn <= 1'b0;
    settle(2);
    check({channel_output, channel_oe, channel_interrupt_flag}, 3'b000);
    @(posedge pclk) presetn <= 1'b1;
    rd(ADDR_CONTROL_TWO, CTRL_TWO_RESET);
    $display("test trigger and reset done");
    final_report();
  end
endmodule : tb_output_compare_pwm_channel
